// ### lsm_pkg.sv
// Constants, register map and command encodings for the load/store multiple sequencer.
package lsm_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] LSM_OFS_CMD = 8'h00;
  localparam logic [7:0] LSM_OFS_LIST = 8'h04;
  localparam logic [7:0] LSM_OFS_STATUS = 8'h08;
  localparam logic [7:0] LSM_OFS_LAST = 8'h0c;

  // Command register fields.
  localparam int LSM_CMD_OP_LSB = 0;
  localparam int LSM_CMD_WB_BIT = 4;
  localparam int LSM_CMD_BASE_LSB = 5;
  localparam int LSM_CMD_COND_BIT = 9;

  // Status register fields.
  localparam int LSM_ST_BUSY_BIT = 0;
  localparam int LSM_ST_DONE_BIT = 1;
  localparam int LSM_ST_EMPTY_BIT = 2;
  localparam int LSM_ST_PCBAD_BIT = 3;
  localparam int LSM_ST_BRANCH_BIT = 4;
  localparam int LSM_ST_SKIP_BIT = 5;

  // Reset values.
  localparam logic [15:0] LSM_LIST_RST = 16'h0000;
  localparam logic [31:0] LSM_WORD_RST = 32'h0000_0000;

  // Architectural register numbers and address step.
  localparam logic [3:0] LSM_PC_IDX = 4'hf;
  localparam logic [31:0] LSM_WORD_BYTES = 32'h0000_0004;

  // Operation spellings accepted in the command opcode field.
  localparam logic [3:0] LSM_OP_LOAD_MULTIPLE = 4'h0;
  localparam logic [3:0] LSM_OP_LOAD_ASC_ALIAS = 4'h1;
  localparam logic [3:0] LSM_OP_FD_POP_ALIAS = 4'h2;
  localparam logic [3:0] LSM_OP_LOAD_DESC = 4'h3;
  localparam logic [3:0] LSM_OP_EA_POP_ALIAS = 4'h4;
  localparam logic [3:0] LSM_OP_STORE_MULTIPLE = 4'h8;
  localparam logic [3:0] LSM_OP_STORE_ASC_ALIAS = 4'h9;
  localparam logic [3:0] LSM_OP_EA_PUSH_ALIAS = 4'ha;
  localparam logic [3:0] LSM_OP_STORE_DESC = 4'hb;
  localparam logic [3:0] LSM_OP_FD_PUSH_ALIAS = 4'hc;

  // Sequencer states.
  typedef enum logic [2:0] {
    LSM_ST_IDLE,
    LSM_ST_BASE,
    LSM_ST_CAPT,
    LSM_ST_PICK,
    LSM_ST_SETUP,
    LSM_ST_XFER,
    LSM_ST_WB,
    LSM_ST_END
  } lsm_state_e;

endpackage : lsm_pkg

// ### lsm_sequencer.sv
// Load/store multiple sequencer: command registers, register file walk and memory transfers.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module lsm_sequencer
  import lsm_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core register file, read combinationally.
  output logic [3:0] rf_rd_idx,
  input wire logic [31:0] rf_rd_data,
  output logic rf_wr_en,
  output logic [3:0] rf_wr_idx,
  output logic [31:0] rf_wr_data,
  // Memory word port.
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Core control.
  output logic branch_valid,
  output logic [31:0] branch_target,
  output logic flags_we,
  output logic busy
);

  // Sequencer state and working registers.
  lsm_state_e state_q;
  logic [15:0] list_q;
  logic [15:0] pend_q;
  logic is_load_q;
  logic desc_q;
  logic wb_q;
  logic [3:0] base_idx_q;
  logic [3:0] cur_q;
  logic [31:0] addr_q;
  logic [31:0] last_q;
  logic [3:0] rf_rd_idx_q;
  logic rf_wr_en_q;
  logic [3:0] rf_wr_idx_q;
  logic [31:0] rf_wr_data_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [31:0] mem_addr_q;
  logic [31:0] mem_wdata_q;
  logic pc_loaded_q;
  logic [31:0] pc_value_q;
  logic branch_valid_q;
  logic [31:0] branch_target_q;
  logic [31:0] reg_rdata_q;
  // Sticky status bits, cleared by the next command write that is taken while idle with a defined opcode.
  logic done_q;
  logic empty_q;
  logic pcbad_q;
  logic branch_q;
  logic skip_q;

  // Command decode of the incoming write.
  logic cmd_wr;
  logic [3:0] cmd_op;
  logic cmd_load;
  logic cmd_desc;
  logic cmd_valid;
  logic [3:0] pick_lo;
  logic [3:0] pick_hi;
  logic [15:0] pend_next;

  // Both scans are plain priority loops; sixteen entries settle well inside one cycle.
  // Lowest set bit of a register list.
  function automatic logic [3:0] lsm_lowest(input logic [15:0] lst);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (lst[i]) begin
        idx = i[3:0];
      end
    end
    return idx;
  endfunction : lsm_lowest

  // Highest set bit of a register list.
  function automatic logic [3:0] lsm_highest(input logic [15:0] lst);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (lst[i]) begin
        idx = i[3:0];
      end
    end
    return idx;
  endfunction : lsm_highest

  // Commands are taken only while idle; a write during a walk is dropped, never queued.
  assign cmd_wr = reg_wr && (reg_addr == LSM_OFS_CMD) && (state_q == LSM_ST_IDLE);
  assign cmd_op = reg_wdata[LSM_CMD_OP_LSB +: 4];

  // alias decode.
  // Every spelling of one operation lands on the same load/direction pair.
  always_comb begin
    cmd_load = 1'b0;
    cmd_desc = 1'b0;
    cmd_valid = 1'b1;
    case (cmd_op)
      LSM_OP_LOAD_MULTIPLE, LSM_OP_LOAD_ASC_ALIAS, LSM_OP_FD_POP_ALIAS: begin
        cmd_load = 1'b1;
      end
      LSM_OP_LOAD_DESC, LSM_OP_EA_POP_ALIAS: begin
        cmd_load = 1'b1;
        cmd_desc = 1'b1;
      end
      LSM_OP_STORE_MULTIPLE, LSM_OP_STORE_ASC_ALIAS, LSM_OP_EA_PUSH_ALIAS: begin
        cmd_load = 1'b0;
      end
      LSM_OP_STORE_DESC, LSM_OP_FD_PUSH_ALIAS: begin
        cmd_desc = 1'b1;
      end
      default: begin
        cmd_valid = 1'b0;
      end
    endcase
  end

  // ascending order and descending order pick.
  assign pick_lo = lsm_lowest(pend_q);
  assign pick_hi = lsm_highest(pend_q);
  assign pend_next = pend_q & ~(16'h0001 << cur_q);

  // Register list register; only software writes it.
  // A write during a walk is harmless, because the walk works on its own snapshot of the list.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      list_q <= LSM_LIST_RST;
    end else if (reg_wr && (reg_addr == LSM_OFS_LIST)) begin
      list_q <= reg_wdata[15:0];
    end
  end

  // Main sequencer: walks the list one word at a time.
  // The memory handshake holds request and address until acknowledged, so a slow memory simply stretches it.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= LSM_ST_IDLE;
      pend_q <= LSM_LIST_RST;
      is_load_q <= 1'b0;
      desc_q <= 1'b0;
      wb_q <= 1'b0;
      base_idx_q <= 4'h0;
      cur_q <= 4'h0;
      addr_q <= LSM_WORD_RST;
      last_q <= LSM_WORD_RST;
      rf_rd_idx_q <= 4'h0;
      rf_wr_en_q <= 1'b0;
      rf_wr_idx_q <= 4'h0;
      rf_wr_data_q <= LSM_WORD_RST;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= LSM_WORD_RST;
      mem_wdata_q <= LSM_WORD_RST;
      pc_loaded_q <= 1'b0;
      pc_value_q <= LSM_WORD_RST;
      branch_valid_q <= 1'b0;
      branch_target_q <= LSM_WORD_RST;
      done_q <= 1'b0;
      empty_q <= 1'b0;
      pcbad_q <= 1'b0;
      branch_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      rf_wr_en_q <= 1'b0;
      branch_valid_q <= 1'b0;
      case (state_q)
        LSM_ST_IDLE: begin
          if (cmd_wr && cmd_valid) begin
            is_load_q <= cmd_load;
            desc_q <= cmd_desc;
            wb_q <= reg_wdata[LSM_CMD_WB_BIT];
            base_idx_q <= reg_wdata[LSM_CMD_BASE_LSB +: 4];
            pend_q <= list_q;
            pc_loaded_q <= 1'b0;
            done_q <= 1'b0;
            empty_q <= 1'b0;
            pcbad_q <= 1'b0;
            branch_q <= 1'b0;
            skip_q <= 1'b0;
            if (!reg_wdata[LSM_CMD_COND_BIT]) begin
              skip_q <= 1'b1;
              state_q <= LSM_ST_END;
            end else if (list_q == 16'h0000) begin
              // An empty list is refused without touching memory.
              empty_q <= 1'b1;
              state_q <= LSM_ST_END;
            end else begin
              rf_rd_idx_q <= reg_wdata[LSM_CMD_BASE_LSB +: 4];
              state_q <= LSM_ST_BASE;
            end
          end
        end
        LSM_ST_BASE: begin
          // The register file needs this cycle to present the base register.
          state_q <= LSM_ST_CAPT;
        end
        LSM_ST_CAPT: begin
          // ascending starts at base and descending starts at base.
          addr_q <= rf_rd_data;
          state_q <= LSM_ST_PICK;
        end
        LSM_ST_PICK: begin
          // The pick also drives the read index, so store data is ready by SETUP.
          cur_q <= desc_q ? pick_hi : pick_lo;
          rf_rd_idx_q <= desc_q ? pick_hi : pick_lo;
          state_q <= LSM_ST_SETUP;
        end
        LSM_ST_SETUP: begin
          // store data from the register file.
          // Loads drive zero on the data lines so no stale register value leaks out.
          mem_req_q <= 1'b1;
          mem_we_q <= !is_load_q;
          mem_addr_q <= addr_q;
          mem_wdata_q <= is_load_q ? LSM_WORD_RST : rf_rd_data;
          state_q <= LSM_ST_XFER;
        end
        LSM_ST_XFER: begin
          // The address moves only after the acknowledge, so a stalled access repeats nothing.
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            last_q <= addr_q;
            pend_q <= pend_next;
            if (is_load_q && (cur_q == LSM_PC_IDX)) begin
              // A loaded program counter is held until the walk completes.
              pc_loaded_q <= 1'b1;
              pc_value_q <= mem_rdata;
            end else if (is_load_q) begin
              rf_wr_en_q <= 1'b1;
              rf_wr_idx_q <= cur_q;
              rf_wr_data_q <= mem_rdata;
            end
            if (desc_q) begin
              addr_q <= addr_q - LSM_WORD_BYTES;
            end else begin
              addr_q <= addr_q + LSM_WORD_BYTES;
            end
            state_q <= (pend_next == 16'h0000) ? LSM_ST_WB : LSM_ST_PICK;
          end
        end
        LSM_ST_WB: begin
          // ascending and descending write-back of the final address.
          // Write-back comes after the last load, so a listed base register ends with the address.
          if (wb_q) begin
            rf_wr_en_q <= 1'b1;
            rf_wr_idx_q <= base_idx_q;
            rf_wr_data_q <= last_q;
          end
          state_q <= LSM_ST_END;
        end
        LSM_ST_END: begin
          // halfword-aligned branch.
          // A clear bit 0 is flagged but the branch still goes; the core decides how to fault.
          if (pc_loaded_q) begin
            branch_valid_q <= 1'b1;
            branch_target_q <= {pc_value_q[31:1], 1'b0};
            branch_q <= 1'b1;
            pcbad_q <= !pc_value_q[0];
          end
          // Sticky status is cleared only by a new command, and that is taken only while idle.
          done_q <= 1'b1;
          state_q <= LSM_ST_IDLE;
        end
        default: begin
          state_q <= LSM_ST_IDLE;
        end
      endcase
    end
  end

  // Register read port: data stands in the cycle after the strobe only.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= LSM_WORD_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        LSM_OFS_LIST: begin
          reg_rdata_q <= {16'h0000, list_q};
        end
        LSM_OFS_STATUS: begin
          reg_rdata_q <= LSM_WORD_RST;
          reg_rdata_q[LSM_ST_BUSY_BIT] <= (state_q != LSM_ST_IDLE);
          reg_rdata_q[LSM_ST_DONE_BIT] <= done_q;
          reg_rdata_q[LSM_ST_EMPTY_BIT] <= empty_q;
          reg_rdata_q[LSM_ST_PCBAD_BIT] <= pcbad_q;
          reg_rdata_q[LSM_ST_BRANCH_BIT] <= branch_q;
          reg_rdata_q[LSM_ST_SKIP_BIT] <= skip_q;
        end
        LSM_OFS_LAST: begin
          reg_rdata_q <= last_q;
        end
        default: begin
          // The command register is write-only; unmapped offsets read as zero.
          reg_rdata_q <= LSM_WORD_RST;
        end
      endcase
    end else begin
      // Outside the read cycle the data lines rest at zero, so nothing stale can be taken.
      reg_rdata_q <= LSM_WORD_RST;
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rdata = reg_rdata_q;
  assign rf_rd_idx = rf_rd_idx_q;
  assign rf_wr_en = rf_wr_en_q;
  assign rf_wr_idx = rf_wr_idx_q;
  assign rf_wr_data = rf_wr_data_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign branch_valid = branch_valid_q;
  assign branch_target = branch_target_q;
  // Busy is decoded from the state, so it falls in the same cycle as the branch pulse.
  assign busy = (state_q != LSM_ST_IDLE);

  // flags untouched.
  // The sequencer never asks the core to update its condition flags.
  assign flags_we = 1'b0;

endmodule : lsm_sequencer

`default_nettype wire

// ### lsm_sequencer_assertions.sv
// Port checker for the load/store multiple sequencer.
`timescale 1ns/100ps
`default_nettype none

module lsm_sequencer_chk
  import lsm_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Memory and register file side.
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic rf_wr_en,
  input wire logic [31:0] rf_wr_data,
  // Core control.
  input wire logic branch_valid,
  input wire logic [31:0] branch_target,
  input wire logic flags_we,
  input wire logic busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [31:0] last_q;
  logic seen_q;
  logic desc_q;

  // Previous access of this command; cleared while idle so two commands never mix.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 32'h0;
      seen_q <= 1'b0;
      desc_q <= 1'b0;
    end else if (!busy) begin
      // The last idle cycle is the command write, so the direction kept is that of the walk.
      seen_q <= 1'b0;
      desc_q <= reg_wdata[3:0] inside {4'h3, 4'h4, 4'hb, 4'hc};
    end else if (mem_req && mem_ack) begin
      last_q <= mem_addr;
      seen_q <= 1'b1;
    end
  end

  // Accepted command write, a waiting access and a finished access.
  sequence s_cmd;
    reg_wr && reg_addr == LSM_OFS_CMD && !busy && reg_wdata[3:0] inside {[4'h0:4'h4], [4'h8:4'hc]};
  endsequence
  sequence s_wait;
    mem_req && !mem_ack;
  endsequence
  sequence s_done;
    mem_req && mem_ack;
  endsequence

  chk_cmd_start: assert property (s_cmd |=> busy) else $error("command not started");
  chk_skip_quiet: assert property (s_cmd ##0 !reg_wdata[9] |=> (!mem_req && !rf_wr_en) [*3]) else $error("skip moved");
  chk_req_hold: assert property (s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("req moved");
  chk_req_drop: assert property (s_done |=> !mem_req) else $error("req held after ack");
  chk_load_data: assert property (s_done ##0 !mem_we ##1 rf_wr_en |-> rf_wr_data == $past(mem_rdata)) else $error("bad load");
  chk_step_addr: assert property ($rose(mem_req) && seen_q |->
    mem_addr == (desc_q ? last_q - 32'h4 : last_q + 32'h4)) else $error("address step not 4");
  chk_branch_pulse: assert property (branch_valid |-> !busy && !branch_target[0] ##1 !branch_valid) else $error("bad branch");
  chk_flags_never: assert property (flags_we == 1'b0) else $error("flags written");
endmodule : lsm_sequencer_chk

bind lsm_sequencer lsm_sequencer_chk u_chk (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .mem_req, .mem_we, .mem_addr,
  .mem_ack, .mem_rdata, .rf_wr_en, .rf_wr_data, .branch_valid, .branch_target, .flags_we, .busy);

`default_nettype wire

// ### lsm_mem_model.sv
// Word memory answering the sequencer after a chosen number of wait cycles.
`timescale 1ns/100ps
`default_nettype none

module lsm_mem_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Request side.
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] wait_cycles,
  // Answer side.
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [64];
  logic [1:0] cnt_q;
  logic [31:0] last_q;

  // Words carry their address, bit 0 set so a loaded PC value is legal.
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {24'h5a5a00, i[5:0], 2'b01};
    end
  end

  // Outside the answer cycle the data lines show the inverse of the last word, never a stale copy.
  assign mem_ack = mem_req && cnt_q == wait_cycles;
  assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~last_q;

  // Wait counter and store path.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      last_q <= 32'h0;
    end else begin
      cnt_q <= (mem_req && !mem_ack) ? cnt_q + 2'h1 : 2'h0;
      if (mem_ack) last_q <= mem_rdata;
      if (mem_ack && mem_we) mem[mem_addr[7:2]] <= mem_wdata;
    end
  end
endmodule : lsm_mem_model

`default_nettype wire

// ### tb.sv
// Self-checking bench for the load/store multiple sequencer.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import lsm_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] wait_cycles = 2'h0;
  logic [31:0] reg_rdata, rf_rd_data, rf_wr_data, mem_addr, mem_wdata, mem_rdata, branch_target;
  logic [3:0] rf_rd_idx, rf_wr_idx;
  logic rf_wr_en, mem_req, mem_we, mem_ack, branch_valid, flags_we, busy;
  logic [31:0] rf [16];
  logic [31:0] aq [$];
  logic [31:0] dq [$];
  int branches;
  int err_count = 0;
  int samples_checked = 0;

  lsm_sequencer u_dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rf_rd_idx, .rf_rd_data,
    .rf_wr_en, .rf_wr_idx, .rf_wr_data, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .branch_valid, .branch_target, .flags_we, .busy);
  lsm_mem_model u_mem (.mclk, .rstn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .wait_cycles, .mem_ack, .mem_rdata);

  // 20 MHz clock; the core register file answers reads at once.
  always #25 mclk = ~mclk;
  assign rf_rd_data = rf[rf_rd_idx];

  // Log accesses and branches, and let writes land in the register file.
  always @(posedge mclk) begin
    if (mem_req && mem_ack) begin
      aq.push_back(mem_addr);
      dq.push_back(mem_wdata);
    end
    if (rf_wr_en) rf[rf_wr_idx] <= rf_wr_data;
    if (branch_valid) branches++;
  end

  function automatic logic [31:0] word(input logic [31:0] a);
    return {24'h5a5a00, a[7:2], 2'b01};
  endfunction : word

  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Bus cycles: one strobe cycle each, read data taken in the following cycle.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // Issue one command and wait, bounded, until the sequencer is idle again.
  task automatic run_op(input logic [3:0] op, input logic wb, input logic [3:0] base, input logic [15:0] list,
                        input logic cnd);
    int n;
    n = 0;
    aq.delete();
    dq.delete();
    branches = 0;
    reg_write(LSM_OFS_LIST, {16'h0, list});
    reg_write(LSM_OFS_CMD, {22'h0, cnd, base, wb, op});
    @(posedge mclk);
    #1;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 200) begin
      check("idle_wait", 32'h0, 32'h1);
      end_of_test();
    end
    @(posedge mclk);
    #1;
  endtask : run_op

  // Loads in every spelling, registers 1,3,5,6 from base r4, slow memory for the descending ones.
  task automatic t_load();
    logic [3:0] regs [4] = '{4'h1, 4'h3, 4'h5, 4'h6};
    logic [31:0] a;
    for (int k = 0; k < 5; k++) begin
      rf[4] = 32'h180;
      wait_cycles <= (k > 2) ? 2'h2 : 2'h0;
      run_op(k[3:0], 1'b1, 4'h4, 16'h006a, 1'b1);
      check("ld_count", 32'h4, 32'(aq.size()));
      for (int j = 0; j < 4; j++) begin
        a = (k > 2) ? 32'h180 - 32'(4 * j) : 32'h180 + 32'(4 * j);
        check("ld_addr", a, aq[j]);
        check("ld_data", word(a), rf[(k > 2) ? regs[3 - j] : regs[j]]);
      end
      check("ld_wb", (k > 2) ? 32'h174 : 32'h18c, rf[4]);
    end
  endtask : t_load

  // Stores of r7 and r9 from base r8 in every spelling, without write-back.
  task automatic t_store();
    logic dsc;
    for (int k = 0; k < 5; k++) begin
      dsc = k > 2;
      rf[8] = 32'h40;
      run_op(4'h8 + k[3:0], 1'b0, 4'h8, 16'h0280, 1'b1);
      check("st_addr0", 32'h40, aq[0]);
      check("st_addr1", dsc ? 32'h3c : 32'h44, aq[1]);
      check("st_data0", dsc ? rf[9] : rf[7], dq[0]);
      check("st_data1", dsc ? rf[7] : rf[9], dq[1]);
      check("st_base", 32'h40, rf[8]);
    end
  endtask : t_store

  // Load into r1 and the PC: one branch to the even form of the loaded word.
  // Then an even word, stored first, is loaded into the PC alone and must raise the bad-bit flag.
  task automatic t_pc();
    logic [31:0] d;
    rf[0] = 32'h20;
    run_op(4'h0, 1'b0, 4'h0, 16'h8002, 1'b1);
    check("pc_branches", 32'h1, 32'(branches));
    check("pc_target", word(32'h24) & ~32'h1, branch_target);
    check("pc_r1", word(32'h20), rf[1]);
    check("pc_base", 32'h20, rf[0]);
    reg_read(LSM_OFS_LAST, d);
    check("pc_last", 32'h24, d);
    reg_read(LSM_OFS_STATUS, d);
    check("pc_status", (32'h1 << LSM_ST_DONE_BIT) | (32'h1 << LSM_ST_BRANCH_BIT), d);
    rf[0] = 32'h30;
    run_op(4'h8, 1'b0, 4'h0, 16'h0400, 1'b1);
    run_op(4'h0, 1'b0, 4'h0, 16'h8000, 1'b1);
    check("pc_even_target", 32'h7000_000a, branch_target);
    reg_read(LSM_OFS_STATUS, d);
    check("pc_bad_flag", (32'h1 << LSM_ST_DONE_BIT) | (32'h1 << LSM_ST_BRANCH_BIT) | (32'h1 << LSM_ST_PCBAD_BIT),
          d);
  endtask : t_pc

  // Reset in the middle of a slow walk: the walk stops at once and the block comes back clean.
  task automatic t_reset();
    logic [31:0] d;
    wait_cycles <= 2'h2;
    reg_write(LSM_OFS_LIST, 32'h0000_00f0);
    reg_write(LSM_OFS_CMD, 32'h0000_0201);
    repeat (6) @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    #1;
    check("rst_busy", 32'h0, {31'h0, busy});
    check("rst_req", 32'h0, {31'h0, mem_req});
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    reg_read(LSM_OFS_LIST, d);
    check("rst_list", 32'h0, d);
    wait_cycles <= 2'h0;
  endtask : t_reset

  // False condition and an undefined opcode leave memory and base alone.
  task automatic t_skip();
    logic [31:0] d;
    rf[2] = 32'h60;
    run_op(4'h0, 1'b1, 4'h2, 16'h0001, 1'b0);
    check("skip_count", 32'h0, 32'(aq.size()));
    check("skip_base", 32'h60, rf[2]);
    reg_read(LSM_OFS_STATUS, d);
    check("skip_flag", 32'h1, {31'h0, d[LSM_ST_SKIP_BIT]});
    run_op(4'h5, 1'b1, 4'h2, 16'h0001, 1'b1);
    check("undef_count", 32'h0, 32'(aq.size()));
    reg_read(8'h10, d);
    check("unmapped", 32'h0, d);
    check("flags_we", 32'h0, {31'h0, flags_we});
  endtask : t_skip

  // Main sequence.
  initial begin
    for (int i = 0; i < 16; i++) begin
      rf[i] = {28'h7000000, i[3:0]};
    end
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_load();
    t_store();
    t_pc();
    t_reset();
    t_skip();
    end_of_test();
  end
endmodule : tb

`default_nettype wire
